/* File: verif/dac_serial_command_port_test.sv */
`timescale 1ns/1ps
// frame-level tests of the command port through the bus master model
module dac_serial_command_port_test;
  // own address with pins 101 and write bit low
  localparam logic [7:0] ADDR = {dsc_pkg::ADDR_FIXED_HI, 3'h5, 1'b0};
  logic mclk, srst, scl, sdaLow, sdaOut, sdaOe, powerDown, ack;
  logic [2:0] addrSelPin;
  logic [dsc_pkg::NUM_DAC-1:0][dsc_pkg::DAC_W-1:0] dacLevel;
  logic [7:0] expLvl [8]; // expected output latches
  logic expPd;
  // second device on the same bus, octal variant, pins 101 give address 0101001
  logic sdaOut8, sdaOe8, powerDown8;
  logic [dsc_pkg::NUM_DAC-1:0][dsc_pkg::DAC_W-1:0] dacLevel8;
  logic [7:0] expLvl8 [8]; // expected octal output latches
  logic expPd8;
  int n_errors = 0;
  int cmp_count = 0;
  // open-drain wire with pull-up: low if anyone pulls
  wire logic devPull = (sdaOe && !sdaOut) || (sdaOe8 && !sdaOut8);
  wire logic sdaIn = !(sdaLow || devPull);
  dsc_command_port #(.OCTAL_VARIANT(1'b0)) dut (.mclk(mclk), .srst(srst), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelPin(addrSelPin), .dacLevel(dacLevel), .powerDown(powerDown));
  dsc_command_port #(.OCTAL_VARIANT(1'b1)) dut8 (.mclk(mclk), .srst(srst), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut8), .sdaOe(sdaOe8), .addrSelPin(addrSelPin), .dacLevel(dacLevel8), .powerDown(powerDown8));
  dsc_bus_master bfm (.scl(scl), .sdaLow(sdaLow), .devPull(devPull));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = !mclk;
  end
  task automatic chk_lvl(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  // compare every channel and the power state, then report the test
  task automatic check_all(input string nm);
    for (int i = 0; i < 8; i++) chk_lvl("dacLevel", expLvl[i], dacLevel[i]);
    chk_bit("powerDown", expPd, powerDown);
    for (int i = 0; i < 8; i++) chk_lvl("dacLevel8", expLvl8[i], dacLevel8[i]);
    chk_bit("powerDown8", expPd8, powerDown8);
    $display("test %s done", nm);
  endtask
  // frame: start, address byte, then command and output pairs
  task automatic open_frame(input logic [7:0] a, input logic e);
    bfm.start_cond();
    bfm.send_byte(a, ack);
    chk_bit("ack", e, ack);
  endtask
  // one command and output pair, each byte acknowledged or not as expected
  task automatic pair(input logic [7:0] c, input logic [7:0] d, input logic e);
    bfm.send_byte(c, ack);
    chk_bit("ack", e, ack);
    bfm.send_byte(d, ack);
    chk_bit("ack", e, ack);
  endtask
  // a command byte with no output byte behind it
  task automatic cmd_byte(input logic [7:0] c);
    bfm.send_byte(c, ack);
    chk_bit("ack", 1'b1, ack);
  endtask
  task automatic close_frame();
    bfm.stop_cond();
    repeat (10) @(posedge mclk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the tests need about 56 us
  initial begin
    #300000;
    n_errors++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    addrSelPin = 3'h5;
    expPd = 1'b0;
    expPd8 = 1'b0;
    for (int i = 0; i < 8; i++) expLvl[i] = 8'h00;
    for (int i = 0; i < 8; i++) expLvl8[i] = 8'h00;
    repeat (4) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (4) @(posedge mclk);
    check_all("reset");
    // the octal device must stay silent on every quad frame, its fifth bit differs
    open_frame(ADDR, 1'b1);
    for (int i = 0; i < 4; i++) pair(8'(i), 8'hA0 + 8'(i), 1'b1);
    chk_lvl("dacLevel", 8'h00, dacLevel[0]);
    close_frame();
    for (int i = 0; i < 4; i++) expLvl[i] = 8'hA0 + 8'(i);
    check_all("write all");
    open_frame(8'h5C, 1'b0);
    pair(8'h00, 8'h5E, 1'b0);
    close_frame();
    open_frame(8'h5B, 1'b0);
    close_frame();
    check_all("foreign address");
    open_frame(ADDR, 1'b1);
    pair(8'h01, 8'h77, 1'b1);
    cmd_byte(8'h08);
    chk_bit("powerDown", 1'b0, powerDown);
    close_frame();
    expLvl[1] = 8'h77;
    expPd = 1'b1;
    check_all("power down");
    open_frame(ADDR, 1'b1);
    cmd_byte(8'h03);
    close_frame();
    expPd = 1'b0;
    check_all("lone command");
    open_frame(ADDR, 1'b1);
    pair(8'h10, 8'hEE, 1'b1);
    pair(8'h02, 8'h33, 1'b1);
    close_frame();
    for (int i = 0; i < 8; i++) expLvl[i] = 8'h00;
    expLvl[2] = 8'h33;
    check_all("clear");
    // the cut command carries its clear bit, which must not take effect
    open_frame(ADDR, 1'b1);
    pair(8'h03, 8'h55, 1'b1);
    bfm.send_bits(8'h18, 4);
    close_frame();
    expLvl[3] = 8'h55;
    check_all("stop in command");
    open_frame(ADDR, 1'b1);
    pair(8'h00, 8'h44, 1'b1);
    cmd_byte(8'h09);
    bfm.send_bits(8'hFF, 4);
    close_frame();
    expLvl[0] = 8'h44;
    expPd = 1'b1;
    check_all("stop in output");
    open_frame(ADDR, 1'b1);
    pair(8'h01, 8'h99, 1'b1);
    open_frame(8'h50, 1'b0);
    close_frame();
    check_all("restart elsewhere");
    open_frame(ADDR, 1'b1);
    cmd_byte(8'h00);
    close_frame();
    expLvl[1] = 8'h99;
    expPd = 1'b0;
    check_all("pending data");
    // quad device: channels four to seven are acknowledged but never stored
    open_frame(ADDR, 1'b1);
    pair(8'h05, 8'hC3, 1'b1);
    close_frame();
    check_all("quad upper select");
    // octal device: fixed fifth bit zero, two pins, all eight channels
    open_frame(8'h52, 1'b1);
    pair(8'h07, 8'h7E, 1'b1);
    pair(8'h04, 8'h4D, 1'b1);
    close_frame();
    expLvl8[7] = 8'h7E;
    expLvl8[4] = 8'h4D;
    check_all("octal channels");
    close_out();
  end
endmodule // dac_serial_command_port_test

/* File: verif/dsc_bus_master.sv */
`timescale 1ns/1ps
// behavioural serial bus master; clock stands high between frames
module dsc_bus_master (
  output logic scl,
  output logic sdaLow,
  input wire logic devPull
);
  localparam int STEP = 30; // link step, each clock phase is two steps
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // start: data falls with clock high
  task automatic start_cond();
    #STEP sdaLow = 1'b0;
    #STEP scl = 1'b1;
    #(2*STEP) sdaLow = 1'b1;
    #(2*STEP) scl = 1'b0;
  endtask
  // data changes only while clock low, msb first
  task automatic send_bits(input logic [7:0] val, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      #STEP sdaLow = !val[i];
      #STEP scl = 1'b1;
      #(2*STEP) scl = 1'b0;
    end
  endtask
  // master also holds data low on the ninth clock
  task automatic send_byte(input logic [7:0] val, output logic ack);
    send_bits(val, 8);
    #STEP sdaLow = 1'b1;
    #STEP scl = 1'b1;
    #STEP ack = devPull;
    #STEP scl = 1'b0;
    #STEP sdaLow = 1'b0;
  endtask
  // stop: data rises with clock high, then bus free
  task automatic stop_cond();
    #STEP sdaLow = 1'b1;
    #STEP scl = 1'b1;
    #(2*STEP) sdaLow = 1'b0;
    #(2*STEP);
  endtask
endmodule // dsc_bus_master

/* File: verif/dsc_command_port_monitor.sv */
`timescale 1ns/1ps
// pin-level checks on acknowledge timing and stop-only updates
module dsc_command_port_monitor #(
  parameter bit OCTAL_VARIANT = 1'b0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [dsc_pkg::NUM_DAC-1:0][dsc_pkg::DAC_W-1:0] dacLevel,
  input wire logic powerDown
);
  // cycles since a stop and since a clock fall; raw pins, so margins are loose
  logic [3:0] stopAge_ff, nxt_stopAge, fallAge_ff, nxt_fallAge;
  logic sdaPrev_ff, sclPrev_ff;
  // ages saturate so a quiet bus never wraps back to zero
  always_comb begin
    nxt_stopAge = (stopAge_ff == 4'hF) ? stopAge_ff : stopAge_ff + 4'h1;
    nxt_fallAge = (fallAge_ff == 4'hF) ? fallAge_ff : fallAge_ff + 4'h1;
    if (scl && sdaIn && !sdaPrev_ff) nxt_stopAge = 4'h0;
    if (sclPrev_ff && !scl) nxt_fallAge = 4'h0;
  end
  // register the ages and the previous pin levels
  always_ff @(posedge mclk) begin
    stopAge_ff <= srst ? 4'hF : nxt_stopAge;
    fallAge_ff <= srst ? 4'hF : nxt_fallAge;
    sdaPrev_ff <= sdaIn;
    sclPrev_ff <= scl;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_ack_drive_low: assert property (sdaOe |-> !sdaOut) else $error("ack drives high");
  a_ack_rise_low: assert property ($rose(sdaOe) |-> !scl) else $error("ack rose with clock high");
  a_ack_after_fall: assert property ($rose(sdaOe) |-> fallAge_ff <= 4'h7) else $error("ack not after fall");
  a_ack_hold_high: assert property (sdaOe && scl |=> sdaOe) else $error("ack dropped in high phase");
  a_ack_release: assert property (sdaOe && fallAge_ff == 4'h0 |-> ##[1:7] !sdaOe) else $error("ack held");
  a_dac_stop_only: assert property ($changed(dacLevel) |-> stopAge_ff < 4'h8) else $error("levels moved");
  a_pd_stop_only: assert property ($changed(powerDown) |-> stopAge_ff < 4'h8) else $error("power moved");
  a_quad_upper_zero: assert property (OCTAL_VARIANT || dacLevel[7:4] == 32'h0) else $error("upper set");
endmodule // dsc_command_port_monitor
bind dsc_command_port dsc_command_port_monitor #(.OCTAL_VARIANT(OCTAL_VARIANT)) u_mon (.mclk(mclk), .srst(srst),
  .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .dacLevel(dacLevel), .powerDown(powerDown));

/* File: verilog/dsc_byte_capture.sv */
`timescale 1ns/1ps
// serial-clock domain: shifts the data line in on every rising clock edge
module dsc_byte_capture (
  input wire logic scl,
  input wire logic sdaIn,
  dsc_link_if.cap link
);
  // shift register, msb first
  logic [7:0] byteSh_ff;
  logic [7:0] nxt_byteSh;

  // next value: oldest bit moves toward the msb
  always_comb begin
    nxt_byteSh = {byteSh_ff[6:0], sdaIn};
  end

  // no reset here: the clock stands still outside frames, and the content is
  // fully replaced by the eight bits of every byte before anyone reads it
  always_ff @(posedge scl) begin
    byteSh_ff <= nxt_byteSh;
  end

  // held stable from one rising edge to the next, read only after a synced edge
  assign link.rxByte = byteSh_ff;
endmodule // dsc_byte_capture

/* File: verilog/dsc_command_port.sv */
`timescale 1ns/1ps
// Functional notes
// - receive-only slave, never starts a transfer
// - serial clock up to 400kHz accepted
// - data falling with clock high is start
// - data rising with clock high is stop
// - eight data clocks then acknowledge low
// - seven bit address, top bits 0101
// - octal variant: fifth bit zero, two pins
// - low address bits come from select pins
// - accept bytes only after own address
// - command and output bytes alternate
// - lone final command: only power/clear act
// - output byte goes to selected input latch
// - all outputs update together at stop
// - power-down takes effect only at stop
// - power-down command still writes its data
// - final power-down hides new data; here dacLevel still takes the new data, only powerDown rises
// - power-down clear resumes from output latches
// - last command byte decides power state
// - clear empties inputs, skips next output
// - stop inside command keeps earlier pairs
// - stop inside output keeps command bits
// - repeated start keeps pending input data
module dsc_command_port #(
  // 1 selects the eight-channel variant, 0 the four-channel one
  parameter bit OCTAL_VARIANT = 1'b0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [2:0] addrSelPin,
  output logic [dsc_pkg::NUM_DAC-1:0][dsc_pkg::DAC_W-1:0] dacLevel,
  output logic powerDown
);
  // byte handed over from the serial-clock domain
  dsc_link_if link ();

  // serial-clock side shift register
  dsc_byte_capture u_capture (
    .scl(scl),
    .sdaIn(sdaIn),
    .link(link)
  );

  // the byte itself is not synchronised: it stands still from the eighth rise
  // to the ninth, and is read only once the synchronised rise has been seen,
  // so a whole clock phase of margin separates use from the next capture

  // synchronisers for both bus lines and the select pins, edge stages for the bus lines only
  logic sclSync1_ff, sclSync2_ff, sclDly_ff;
  logic sdaSync1_ff, sdaSync2_ff, sdaDly_ff;
  logic [2:0] addrSync1_ff, addrSync2_ff;
  logic nxt_sclSync1, nxt_sclSync2, nxt_sclDly;
  logic nxt_sdaSync1, nxt_sdaSync2, nxt_sdaDly;
  logic [2:0] nxt_addrSync1, nxt_addrSync2;

  // protocol state
  dsc_pkg::dsc_state_t state_ff, nxt_state;
  logic [3:0] bitCnt_ff, nxt_bitCnt; // position in the nine-clock slot
  logic ackWant_ff, nxt_ackWant; // current byte is to be acknowledged
  logic sdaOe_ff, nxt_sdaOe; // pulling the data line low
  logic cmdSeen_ff, nxt_cmdSeen; // a whole command byte arrived since start
  logic pdPend_ff, nxt_pdPend; // power state to apply at stop
  logic clrSkip_ff, nxt_clrSkip; // drop the output byte after a clear
  logic [dsc_pkg::SEL_W-1:0] sel_ff, nxt_sel; // channel picked by the command
  logic [dsc_pkg::NUM_DAC-1:0][dsc_pkg::DAC_W-1:0] inLatch_ff, nxt_inLatch;
  logic [dsc_pkg::NUM_DAC-1:0][dsc_pkg::DAC_W-1:0] outLatch_ff, nxt_outLatch;
  logic powerDown_ff, nxt_powerDown;
  logic sdaOut_ff, nxt_sdaOut;

  // decoded bus events
  // the decode below reads synchronised copies of the pins; only the received byte is taken unsynchronised
  logic sclRise, sclFall, startSeen, stopSeen;
  logic byteDone;
  logic [dsc_pkg::ADDR_W-1:0] ownAddr;
  logic addrMatch;
  logic selValid;

  // next values of the synchroniser chains
  // latency of a few system cycles is tiny against the shortest clock phase
  always_comb begin
    nxt_sclSync1 = scl;
    nxt_sclSync2 = sclSync1_ff;
    nxt_sclDly = sclSync2_ff;
    nxt_sdaSync1 = sdaIn;
    nxt_sdaSync2 = sdaSync1_ff;
    nxt_sdaDly = sdaSync2_ff;
    nxt_addrSync1 = addrSelPin;
    nxt_addrSync2 = addrSync1_ff;
  end

  // register the chains; idle bus reads high
  always_ff @(posedge mclk) begin
    if (srst) begin
      sclSync1_ff <= 1'b1;
      sclSync2_ff <= 1'b1;
      sclDly_ff <= 1'b1;
      sdaSync1_ff <= 1'b1;
      sdaSync2_ff <= 1'b1;
      sdaDly_ff <= 1'b1;
      addrSync1_ff <= 3'h0;
      addrSync2_ff <= 3'h0;
    end else begin
      sclSync1_ff <= nxt_sclSync1;
      sclSync2_ff <= nxt_sclSync2;
      sclDly_ff <= nxt_sclDly;
      sdaSync1_ff <= nxt_sdaSync1;
      sdaSync2_ff <= nxt_sdaSync2;
      sdaDly_ff <= nxt_sdaDly;
      addrSync1_ff <= nxt_addrSync1;
      addrSync2_ff <= nxt_addrSync2;
    end
  end

  // edge and condition decode, only from second and third stages
  always_comb begin
    sclRise = sclSync2_ff & ~sclDly_ff;
    sclFall = ~sclSync2_ff & sclDly_ff;
    // data falls while the clock stays high
    startSeen = sclSync2_ff & sclDly_ff & sdaDly_ff & ~sdaSync2_ff;
    // data rises while the clock stays high
    stopSeen = sclSync2_ff & sclDly_ff & ~sdaDly_ff & sdaSync2_ff;
    // the eighth rising edge completes the data part of a byte
    byteDone = sclRise & (bitCnt_ff == dsc_pkg::CNT_LAST_DATA);
  end

  // own slave address from fixed bits and the select pins
  always_comb begin
    // fixed top bits; octal variant adds a fixed zero
    // remaining low bits follow the select pins
    if (OCTAL_VARIANT) begin
      ownAddr = {dsc_pkg::ADDR_FIXED_HI, dsc_pkg::ADDR_OCTAL_FIX, addrSync2_ff[1:0]};
    end else begin
      ownAddr = {dsc_pkg::ADDR_FIXED_HI, addrSync2_ff[2:0]};
    end
    // only writes are served; a read address is left unanswered
    addrMatch = (link.rxByte[7:1] == ownAddr) & ~link.rxByte[dsc_pkg::RW_BIT];
    // the four-channel variant has no channels four to seven
    selValid = OCTAL_VARIANT | (sel_ff < dsc_pkg::SEL_W'(dsc_pkg::QUAD_DAC));
  end

  // a stop or start wins over everything else in the same cycle, since the
  // bus master may end or restart a frame in the middle of any byte
  // protocol next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_ackWant = ackWant_ff;
    nxt_sdaOe = sdaOe_ff;
    nxt_cmdSeen = cmdSeen_ff;
    nxt_pdPend = pdPend_ff;
    nxt_clrSkip = clrSkip_ff;
    nxt_sel = sel_ff;
    nxt_inLatch = inLatch_ff;
    nxt_outLatch = outLatch_ff;
    nxt_powerDown = powerDown_ff;
    // the line is only ever pulled low, never driven high
    nxt_sdaOut = 1'b0;
    if (stopSeen) begin
      // all channels take their input latch at once
      // a partial byte never reached the latches, earlier pairs stay
      // only a stop closing a frame to us with a command transfers
      if (((state_ff == dsc_pkg::ST_CMD) || (state_ff == dsc_pkg::ST_DATA)) && cmdSeen_ff) begin
        nxt_outLatch = inLatch_ff;
        // power-down applied here, not at the command byte
        // dacLevel still shows the new data; clear resumes from out latches
        nxt_powerDown = pdPend_ff;
      end
      nxt_state = dsc_pkg::ST_IDLE;
      nxt_bitCnt = dsc_pkg::CNT_ZERO;
      nxt_ackWant = 1'b0;
      nxt_sdaOe = 1'b0;
      nxt_cmdSeen = 1'b0;
      nxt_clrSkip = 1'b0;
    end else if (startSeen) begin
      // repeated start keeps input latches, only the frame restarts
      // every start opens address matching again
      nxt_state = dsc_pkg::ST_ADDR;
      nxt_bitCnt = dsc_pkg::CNT_ZERO;
      nxt_ackWant = 1'b0;
      nxt_sdaOe = 1'b0;
      nxt_cmdSeen = 1'b0;
      nxt_clrSkip = 1'b0;
    end else if (state_ff != dsc_pkg::ST_IDLE) begin
      // count the nine clocks of each byte slot
      if (sclRise) begin
        if (bitCnt_ff == dsc_pkg::CNT_ACK) begin
          nxt_bitCnt = dsc_pkg::CNT_ZERO;
        end else begin
          nxt_bitCnt = bitCnt_ff + 4'h1;
        end
      end
      // pull low from the fall after bit eight to the fall after clock nine
      if (sclFall) begin
        nxt_sdaOe = (bitCnt_ff == dsc_pkg::CNT_ACK) & ackWant_ff;
      end
      if (byteDone) begin
        nxt_ackWant = 1'b0;
        unique case (state_ff)
          dsc_pkg::ST_ADDR: begin
            // a foreign address leaves us deaf until the next start
            if (addrMatch) begin
              nxt_ackWant = 1'b1;
              nxt_state = dsc_pkg::ST_CMD;
            end else begin
              nxt_state = dsc_pkg::ST_IGNORE;
            end
          end
          dsc_pkg::ST_CMD: begin
            // bits 7..5 reserved, then clear, power, select
            // each command overwrites the pending power state
            // power and clear act even if no output byte follows
            // a stop inside the next byte still keeps these bits
            nxt_ackWant = 1'b1;
            nxt_cmdSeen = 1'b1;
            nxt_pdPend = link.rxByte[dsc_pkg::CMD_PD_BIT];
            nxt_sel = link.rxByte[dsc_pkg::CMD_SEL_MSB:0];
            nxt_clrSkip = link.rxByte[dsc_pkg::CMD_CLR_BIT];
            // clear empties every input latch right away
            if (link.rxByte[dsc_pkg::CMD_CLR_BIT]) begin
              for (int i = 0; i < dsc_pkg::NUM_DAC; i++) begin
                nxt_inLatch[i] = dsc_pkg::DAC_RST;
              end
            end
            // an output byte is expected next
            nxt_state = dsc_pkg::ST_DATA;
          end
          dsc_pkg::ST_DATA: begin
            nxt_ackWant = 1'b1;
            // data lands in the selected channel; even with power-down
            // the output byte after a clear is dropped
            if (!clrSkip_ff && selValid) begin
              nxt_inLatch[sel_ff] = link.rxByte;
            end
            nxt_clrSkip = 1'b0;
            nxt_state = dsc_pkg::ST_CMD;
          end
          dsc_pkg::ST_IGNORE: begin
            nxt_state = dsc_pkg::ST_IGNORE;
          end
          default: begin
            nxt_state = dsc_pkg::ST_IDLE;
          end
        endcase
      end
      // an illegal code falls back to idle at once
      if (state_ff > dsc_pkg::ST_IGNORE) begin
        nxt_state = dsc_pkg::ST_IDLE;
      end
    end
  end

  // register the protocol state
  // latches clear and the device runs powered up after reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= dsc_pkg::ST_IDLE;
      bitCnt_ff <= dsc_pkg::CNT_ZERO;
      ackWant_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      cmdSeen_ff <= 1'b0;
      pdPend_ff <= dsc_pkg::PD_RST;
      clrSkip_ff <= 1'b0;
      sel_ff <= 3'h0;
      for (int i = 0; i < dsc_pkg::NUM_DAC; i++) begin
        inLatch_ff[i] <= dsc_pkg::DAC_RST;
        outLatch_ff[i] <= dsc_pkg::DAC_RST;
      end
      powerDown_ff <= dsc_pkg::PD_RST;
      sdaOut_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      ackWant_ff <= nxt_ackWant;
      sdaOe_ff <= nxt_sdaOe;
      cmdSeen_ff <= nxt_cmdSeen;
      pdPend_ff <= nxt_pdPend;
      clrSkip_ff <= nxt_clrSkip;
      sel_ff <= nxt_sel;
      inLatch_ff <= nxt_inLatch;
      outLatch_ff <= nxt_outLatch;
      powerDown_ff <= nxt_powerDown;
      sdaOut_ff <= nxt_sdaOut;
    end
  end

  // outputs straight from flip-flops
  // sdaOut never leaves zero: the pin is open drain, sdaOe alone decides
  assign sdaOut = sdaOut_ff;
  assign sdaOe = sdaOe_ff;
  // output latch stays visible in power-down; the analog side decides to float
  assign dacLevel = outLatch_ff;
  assign powerDown = powerDown_ff;
endmodule // dsc_command_port

/* File: verilog/dsc_link_if.sv */
`timescale 1ns/1ps
// carries the byte shifted in on the serial clock over to the system-clock logic
interface dsc_link_if;
  logic [7:0] rxByte;
  modport cap (output rxByte);
  modport ctl (input rxByte);
endinterface

/* File: verilog/dsc_pkg.sv */
package dsc_pkg;
  // fixed upper slave address bits, and the extra fixed bit of the octal variant
  localparam logic [3:0] ADDR_FIXED_HI = 4'h5;
  localparam logic ADDR_OCTAL_FIX = 1'b0;
  localparam int ADDR_W = 7;
  // command byte field positions
  localparam int CMD_CLR_BIT = 4;
  localparam int CMD_PD_BIT = 3;
  localparam int CMD_SEL_MSB = 2;
  localparam int SEL_W = 3;
  // read/write bit position in the address byte
  localparam int RW_BIT = 0;
  // channel count and width of each latch
  localparam int NUM_DAC = 8;
  localparam int QUAD_DAC = 4;
  localparam int DAC_W = 8;
  // bit counter values inside one nine-clock byte slot
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  // reset values
  localparam logic [7:0] DAC_RST = 8'h00;
  localparam logic PD_RST = 1'b0;
  // highest serial clock rate accepted, and the system clock it is sampled with
  localparam int SCL_MAX_KHZ = 400;
  localparam int MCLK_PERIOD_NS = 4;
  localparam int SCL_LOW_MIN_NS = 1300;
  // cycles of the system clock in the shortest clock-low phase, rounded down
  localparam int SCL_LOW_MIN_CYC = SCL_LOW_MIN_NS / MCLK_PERIOD_NS;
  // synchroniser plus edge stage latency must fit well inside the low phase
  localparam int SYNC_LAT_CYC = 3;

  // transfer state; codes 5..7 are illegal
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_CMD = 3'h2,
    ST_DATA = 3'h3,
    ST_IGNORE = 3'h4
  } dsc_state_t;
endpackage
